//--- wwdtc_pkg.sv
// constants and types shared by the windowed watchdog control block
package wwdtc_pkg;

  // apb geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFF_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h0c;
  localparam logic [7:0] OFF_TIMER_STATUS = 8'h10;
  localparam logic [7:0] OFF_CAUSE = 8'h14;

  // control_0 field positions
  localparam int unsigned C0_SEN_BIT = 0;
  localparam int unsigned C0_PS_LSB = 1;
  // control_1 field positions
  localparam int unsigned C1_WIN_LSB = 0;
  localparam int unsigned C1_CS_LSB = 4;
  // timer status field positions
  localparam int unsigned TS_ARMED_BIT = 2;
  localparam int unsigned TS_WIN_LSB = 3;
  // cause field positions
  localparam int unsigned CA_TMO_BIT = 0;
  localparam int unsigned CA_WV_BIT = 1;

  // field widths and codes
  localparam logic [4:0] PS_ALL_ONES = 5'h1f;
  localparam logic [4:0] PS_RESET_DEFAULT = 5'h0b;
  localparam logic [4:0] PS_MAX_VALID = 5'h12;
  localparam logic [4:0] PS_MIN = 5'h00;
  localparam logic [2:0] CS_ALL_ONES = 3'h7;
  localparam logic [2:0] CS_RESET_DEFAULT = 3'h0;
  localparam logic [2:0] CS_LF_OSC = 3'h0;
  localparam logic [2:0] CS_MF_OSC = 3'h1;
  localparam logic [2:0] CS_SEC_OSC = 3'h2;
  localparam logic [2:0] WIN_ALL_ONES = 3'h7;
  localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
  localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;

  // counter geometry: 18-bit prescaler below a 5-bit window timer
  localparam int unsigned CNT_W = 23;
  localparam int unsigned PRESCALE_W = 18;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 23'h7fffff;

  // secondary oscillator start-up, in its own clocks
  localparam logic [10:0] SOSC_START_CLOCKS = 11'h400;
  // cycles after reset release before synchronised straps are loaded
  localparam logic [1:0] INIT_CYCLES = 2'h2;

  // reset values
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 23'h000000;

  // block state: gray coded along init -> run -> start-up wait
  typedef enum logic [1:0] {
    WWDTC_INIT = 2'b00,
    WWDTC_RUN = 2'b01,
    WWDTC_OSC_WAIT = 2'b11
  } wwdtc_state_t;

endpackage

//--- wwdtc_tick.sv
// synchroniser and rising-edge detector for one slow oscillator input
`timescale 1ns/100ps
module wwdtc_tick (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // slow oscillator sampled as data
  input wire logic osc,
  // one-cycle pulse per oscillator rising edge
  output logic tick
);

  logic sync1_r, sync2_r, last_r, tick_r;
  logic sync1_nxt, sync2_nxt, last_nxt, tick_nxt;

  // next values: first flop feeds only the second
  always_comb begin
    sync1_nxt = osc;
    sync2_nxt = sync1_r;
    last_nxt = sync2_r;
    tick_nxt = sync2_r & ~last_r;
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      last_r <= last_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

//--- wwdtc_top.sv
// windowed watchdog control: apb registers, prescaled counter, window and time-out logic
//
// How it works
// R1: period code picks ratio 1:32 doubling to 1:8388608
// R2: codes 10011..11111 act as 1:32
// R3: reset loads 01011 if config ones, else config
// R4: period writable only when config all ones
// R5: enable bit matters only in software mode
// R6: clock select picks low, mid or secondary oscillator
// R7: clock select resets to 000 when config 111
// R8: clock select read-only unless config is 111
// R9: window code sets closed fraction in eighths
// R10: window field resets from window config
// R11: window read-only unless config is 111
// R12: live 18-bit prescaler readable, resets zero
// R13: software reads prescaler bytes only for debug
// R14: secondary oscillator restarts, waits 1024 clocks
// R15: unimplemented control bits read zero
// R16: time-out is ratio times selected clock period
// R17: mode config picks on, sleep-off, software, off
// R18: clear needs prior control_0 read when windowed
// R19: window open from five timer msbs vs boundary
// R20: control register writes clear the counter
// R21: time-out while awake gives one reset pulse
`timescale 1ns/100ps
module wwdtc_top
  import wwdtc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wwdtc_pkg::ADDR_W-1:0] paddr,
  input wire logic [wwdtc_pkg::DATA_W-1:0] pwdata,
  output logic [wwdtc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration straps
  input wire logic [1:0] mode_config_field,
  input wire logic [4:0] period_config_field,
  input wire logic [2:0] clock_config_field,
  input wire logic [2:0] window_config_field,
  // core side
  input wire logic sleep,
  input wire logic clear_watchdog,
  // watchdog time bases
  input wire logic low_freq_internal_osc,
  input wire logic mid_freq_internal_osc,
  input wire logic secondary_osc,
  // results
  output logic reset_req,
  output logic wake_req,
  output logic wdt_active
);
  import wwdtc_pkg::*;

  // limit the period code to the valid range
  function automatic logic [4:0] ps_limit(input logic [4:0] p);
    ps_limit = (p > PS_MAX_VALID) ? PS_MIN : p; // R2
  endfunction

  // last count of the period: ratio 2^(5+p) minus one
  function automatic logic [CNT_W-1:0] period_last(input logic [4:0] p);
    period_last = CNT_ALL_ONES >> (PS_MAX_VALID - p); // R1 R16
  endfunction

  // five most significant timer bits of the current period
  function automatic logic [4:0] timer_msbs(input logic [CNT_W-1:0] c, input logic [4:0] p);
    logic [CNT_W-1:0] s;
    s = c >> p;
    timer_msbs = s[4:0];
  endfunction

  // oscillator ticks
  logic tick_lf, tick_mf, tick_sec;

  wwdtc_tick u_tick_lf (.pclk(pclk), .presetn(presetn), .osc(low_freq_internal_osc), .tick(tick_lf));
  wwdtc_tick u_tick_mf (.pclk(pclk), .presetn(presetn), .osc(mid_freq_internal_osc), .tick(tick_mf));
  wwdtc_tick u_tick_sec (.pclk(pclk), .presetn(presetn), .osc(secondary_osc), .tick(tick_sec));

  // state
  wwdtc_state_t state_r, state_nxt;
  logic [12:0] cfg_s1_r, cfg_s1_nxt, cfg_s2_r, cfg_s2_nxt;
  logic [1:0] init_cnt_r, init_cnt_nxt;
  logic [4:0] ps_r, ps_nxt;
  logic sen_r, sen_nxt;
  logic [2:0] cs_r, cs_nxt;
  logic [2:0] win_r, win_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic armed_r, armed_nxt;
  logic tmo_flag_r, tmo_flag_nxt;
  logic wv_flag_r, wv_flag_nxt;
  logic [10:0] osc_cnt_r, osc_cnt_nxt;
  logic sleep_d_r, sleep_d_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic reset_req_r, reset_req_nxt;
  logic wake_req_r, wake_req_nxt;
  logic active_r, active_nxt;

  // decoded helpers
  logic [1:0] cfg_mode;
  logic [4:0] cfg_period;
  logic [2:0] cfg_clock, cfg_window;
  logic [4:0] ps_eff, win_msbs, win_bound;
  logic setup, access, wr_c0, wr_c1, wr_cause, rd_c0;
  logic win_open, windowed, tick_sel, active, last_hit;

  // strap fields from the second synchroniser stage
  always_comb begin
    cfg_mode = cfg_s2_r[12:11];
    cfg_period = cfg_s2_r[10:6];
    cfg_clock = cfg_s2_r[5:3];
    cfg_window = cfg_s2_r[2:0];
  end

  // bus phase and register strobes
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & pready_r;
    wr_c0 = access & pwrite & (paddr == OFF_CONTROL_0);
    wr_c1 = access & pwrite & (paddr == OFF_CONTROL_1);
    wr_cause = access & pwrite & (paddr == OFF_CAUSE);
    rd_c0 = access & ~pwrite & (paddr == OFF_CONTROL_0);
  end

  // period, window and time base decode
  always_comb begin
    ps_eff = ps_limit(ps_r);
    win_msbs = timer_msbs(cnt_r, ps_eff); // R19
    win_bound = {3'h7 - win_r, 2'b00}; // R9
    win_open = (win_msbs >= win_bound); // R19
    windowed = (win_r != WIN_ALL_ONES);
    last_hit = (cnt_r == period_last(ps_eff));
    tick_sel = (cs_r == CS_LF_OSC) ? tick_lf : (cs_r == CS_MF_OSC) ? tick_mf : // R6
      (cs_r == CS_SEC_OSC) ? tick_sec : 1'b0;
    // R17
    case (cfg_mode)
      MODE_ALWAYS_ON: active = 1'b1;
      MODE_OFF_IN_SLEEP: active = ~sleep;
      MODE_SOFTWARE: active = sen_r; // R5
      default: active = 1'b0;
    endcase
  end

  // apb read data and answer, registered in the setup phase
  always_comb begin
    prdata_nxt = RDATA_RESET;
    pslverr_nxt = 1'b0;
    pready_nxt = setup;
    if (setup) begin
      if (paddr == OFF_CONTROL_0) begin
        prdata_nxt[C0_SEN_BIT] = sen_r; // R15
        prdata_nxt[C0_PS_LSB +: 5] = ps_r;
      end else if (paddr == OFF_CONTROL_1) begin
        prdata_nxt[C1_WIN_LSB +: 3] = win_r; // R15
        prdata_nxt[C1_CS_LSB +: 3] = cs_r;
      end else if (paddr == OFF_COUNT_LOW) begin
        prdata_nxt[7:0] = cnt_r[7:0]; // R12
      end else if (paddr == OFF_COUNT_HIGH) begin
        prdata_nxt[7:0] = cnt_r[15:8]; // R12
      end else if (paddr == OFF_TIMER_STATUS) begin
        prdata_nxt[1:0] = cnt_r[PRESCALE_W-1:16]; // R12
        prdata_nxt[TS_ARMED_BIT] = armed_r;
        prdata_nxt[TS_WIN_LSB +: 5] = win_msbs;
      end else if (paddr == OFF_CAUSE) begin
        prdata_nxt[CA_TMO_BIT] = tmo_flag_r;
        prdata_nxt[CA_WV_BIT] = wv_flag_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // control, counter and event next state
  always_comb begin
    state_nxt = state_r;
    cfg_s1_nxt = {mode_config_field, period_config_field, clock_config_field, window_config_field};
    cfg_s2_nxt = cfg_s1_r;
    init_cnt_nxt = init_cnt_r;
    ps_nxt = ps_r;
    sen_nxt = sen_r;
    cs_nxt = cs_r;
    win_nxt = win_r;
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    tmo_flag_nxt = tmo_flag_r;
    wv_flag_nxt = wv_flag_r;
    osc_cnt_nxt = osc_cnt_r;
    sleep_d_nxt = sleep;
    reset_req_nxt = 1'b0;
    wake_req_nxt = 1'b0;
    active_nxt = 1'b0;
    // software writes, only to unlocked fields
    if (wr_c0) begin
      sen_nxt = pwdata[C0_SEN_BIT];
      if (cfg_period == PS_ALL_ONES) begin
        ps_nxt = pwdata[C0_PS_LSB +: 5]; // R4
      end
    end
    if (wr_c1) begin
      if (cfg_clock == CS_ALL_ONES) begin
        cs_nxt = pwdata[C1_CS_LSB +: 3]; // R8
      end
      if (cfg_window == WIN_ALL_ONES) begin
        win_nxt = pwdata[C1_WIN_LSB +: 3]; // R11
      end
    end
    // reading control_0 arms the clear
    if (rd_c0) begin
      armed_nxt = 1'b1; // R18
    end
    // cause flags are write-one-to-clear; later sets win
    if (wr_cause) begin
      if (pwdata[CA_TMO_BIT]) begin
        tmo_flag_nxt = 1'b0;
      end
      if (pwdata[CA_WV_BIT]) begin
        wv_flag_nxt = 1'b0;
      end
    end
    case (state_r)
      WWDTC_INIT: begin
        init_cnt_nxt = init_cnt_r + 2'h1;
        if (init_cnt_r == INIT_CYCLES) begin
          ps_nxt = (cfg_period == PS_ALL_ONES) ? PS_RESET_DEFAULT : cfg_period; // R3
          cs_nxt = (cfg_clock == CS_ALL_ONES) ? CS_RESET_DEFAULT : cfg_clock; // R7
          win_nxt = cfg_window; // R10
          state_nxt = WWDTC_RUN;
        end
      end
      WWDTC_RUN: begin
        active_nxt = active;
        if (!active || (sleep != sleep_d_r) || wr_c0 || wr_c1) begin
          cnt_nxt = CNT_RESET; // R20
        end else if (clear_watchdog && windowed && (!armed_r || !win_open)) begin
          reset_req_nxt = 1'b1; // R18
          wv_flag_nxt = 1'b1;
          cnt_nxt = CNT_RESET;
          armed_nxt = 1'b0;
        end else if (clear_watchdog) begin
          cnt_nxt = CNT_RESET;
          armed_nxt = 1'b0;
        end else if (tick_sel && last_hit) begin
          cnt_nxt = CNT_RESET;
          armed_nxt = 1'b0;
          if (sleep) begin
            wake_req_nxt = 1'b1;
          end else begin
            reset_req_nxt = 1'b1; // R21
            tmo_flag_nxt = 1'b1;
            if (cs_r == CS_SEC_OSC) begin
              osc_cnt_nxt = 11'h000; // R14
              state_nxt = WWDTC_OSC_WAIT;
            end
          end
        end else if (tick_sel) begin
          cnt_nxt = cnt_r + 23'h000001; // R16
        end
      end
      WWDTC_OSC_WAIT: begin
        // counter held clear while the secondary oscillator restarts
        cnt_nxt = CNT_RESET;
        if (tick_sec) begin
          osc_cnt_nxt = osc_cnt_r + 11'h001;
        end
        if (osc_cnt_r == SOSC_START_CLOCKS) begin
          state_nxt = WWDTC_RUN; // R14
        end
      end
      default: begin
        state_nxt = WWDTC_INIT;
      end
    endcase
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= WWDTC_INIT;
      cfg_s1_r <= 13'h0000;
      cfg_s2_r <= 13'h0000;
      init_cnt_r <= 2'h0;
      ps_r <= PS_RESET_DEFAULT;
      sen_r <= 1'b0;
      cs_r <= CS_RESET_DEFAULT;
      win_r <= WIN_ALL_ONES;
      cnt_r <= CNT_RESET; // R12
      armed_r <= 1'b0;
      tmo_flag_r <= 1'b0;
      wv_flag_r <= 1'b0;
      osc_cnt_r <= 11'h000;
      sleep_d_r <= 1'b0;
      prdata_r <= RDATA_RESET;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      reset_req_r <= 1'b0;
      wake_req_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_s1_r <= cfg_s1_nxt;
      cfg_s2_r <= cfg_s2_nxt;
      init_cnt_r <= init_cnt_nxt;
      ps_r <= ps_nxt;
      sen_r <= sen_nxt;
      cs_r <= cs_nxt;
      win_r <= win_nxt;
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      tmo_flag_r <= tmo_flag_nxt;
      wv_flag_r <= wv_flag_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      sleep_d_r <= sleep_d_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      reset_req_r <= reset_req_nxt;
      wake_req_r <= wake_req_nxt;
      active_r <= active_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign reset_req = reset_req_r;
  assign wake_req = wake_req_r;
  assign wdt_active = active_r;

endmodule

//--- wwdtc_top_chk.sv
// concurrent checks on the ports of the windowed watchdog control block
`timescale 1ns/100ps
module wwdtc_top_chk
  import wwdtc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wwdtc_pkg::ADDR_W-1:0] paddr,
  input wire logic [wwdtc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // straps and results
  input wire logic [1:0] mode_config_field,
  input wire logic reset_req,
  input wire logic wake_req,
  input wire logic wdt_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  // setup phase of a transfer
  assign setup = psel && !penable;
  chk_ready_after_setup: assert property (setup |=> pready && psel && penable) else $error("no answer after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
  chk_err_unmapped: assert property (setup && paddr >= 8'h18 |=> pslverr) else $error("unmapped not refused");
  chk_err_zero_data: assert property (pslverr |-> pready && prdata == '0) else $error("error without zero data");
  chk_c0_unused_zero: assert property (setup && !pwrite && paddr == OFF_CONTROL_0 |=> prdata[31:6] == '0)
    else $error("control 0 unused bits set");
  chk_c1_unused_zero: assert property (setup && !pwrite && paddr == OFF_CONTROL_1 |=>
    prdata[31:7] == '0 && !prdata[3]) else $error("control 1 unused bits set");
  chk_reset_one_pulse: assert property (reset_req |=> !reset_req) else $error("reset request too long");
  chk_off_inactive: assert property (mode_config_field == MODE_OFF |-> !wdt_active) else $error("active when off");
  chk_wake_not_reset: assert property (wake_req |-> !reset_req) else $error("wake and reset together");
  // main scenarios
  cover property (reset_req);
  cover property (wake_req);
  cover property (pslverr);
  cover property (setup && pwrite && paddr == OFF_CONTROL_1);
endmodule
bind wwdtc_top wwdtc_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mode_config_field(mode_config_field), .reset_req(reset_req), .wake_req(wake_req), .wdt_active(wdt_active));

//--- wwdtc_top_test.sv
// self-checking testbench for the windowed watchdog control block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module wwdtc_top_test;
  import wwdtc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sleep, clear_watchdog, pready, pslverr, e;
  logic reset_req, wake_req, wdt_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [1:0] mode;
  logic [4:0] pcfg;
  logic [2:0] ccfg, wcfg, osc;
  int errors = 0;
  int checks = 0;
  int hit, r, wk;
  int pst[4] = '{0, 1, 19, 31};
  int sel[4] = '{0, 1, 0, 0};

  wwdtc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_config_field(mode), .period_config_field(pcfg), .clock_config_field(ccfg),
    .window_config_field(wcfg), .sleep(sleep), .clear_watchdog(clear_watchdog),
    .low_freq_internal_osc(osc[0]), .mid_freq_internal_osc(osc[1]), .secondary_osc(osc[2]),
    .reset_req(reset_req), .wake_req(wake_req), .wdt_active(wdt_active));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // prints the counts and the verdict, then stops
  task wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // model of the time-out length in oscillator ticks; reserved codes act as the shortest
  function automatic int ticks(input int ps);
    return (ps > 18) ? 32 : (32 << ps);
  endfunction

  // one apb transfer, request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset with new straps, which stay static afterwards
  task restart(input logic [1:0] m, input logic [4:0] p, input logic [2:0] c, input logic [2:0] w);
    presetn <= 1'b0;
    mode <= m;
    pcfg <= p;
    ccfg <= c;
    wcfg <= w;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // runs one oscillator for n rising edges, noting the edge count at a reset or wake request
  task spin(input int s, input int n);
    r = 0;
    hit = -1;
    wk = -1;
    for (int c = 0; c < 16 * n; c++) begin
      @(posedge pclk);
      if (reset_req === 1'b1 && hit < 0) hit = r;
      if (wake_req === 1'b1 && wk < 0) wk = r;
      if (c % 8 == 0) begin
        if (osc[s] == 1'b0) r++;
        osc[s] <= ~osc[s];
      end
    end
  endtask

  // one clear pulse, then watch for a violation reset
  task pulse;
    @(posedge pclk);
    clear_watchdog <= 1'b1;
    @(posedge pclk);
    clear_watchdog <= 1'b0;
    hit = 0;
    repeat (4) begin
      @(posedge pclk);
      if (reset_req === 1'b1) hit = 1;
    end
  endtask

  // watchdog: the whole sequence needs well under half a millisecond
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, sleep, clear_watchdog, presetn} = '0;
    {paddr, pwdata, osc} = '0;
    {mode, pcfg, ccfg, wcfg} = '0;
    d = $urandom(26);
    restart(2'h1, 5'h1f, 3'h7, 3'h7);
    apb(0, OFF_CONTROL_0, 0);
    `CHK(q, 32'h16)
    apb(0, OFF_CONTROL_1, 0);
    `CHK(q, 32'h07)
    apb(0, OFF_COUNT_LOW, 0);
    `CHK(q, 32'h0)
    apb(0, OFF_COUNT_HIGH, 0);
    `CHK(q, 32'h0)
    apb(0, OFF_TIMER_STATUS, 0);
    `CHK(q[1:0], 2'b00)
    d = $urandom;
    apb(1, OFF_CONTROL_0, d);
    apb(0, OFF_CONTROL_0, 0);
    `CHK(q, {26'h0, d[5:0]})
    `CHK(wdt_active, d[0])
    apb(1, OFF_CONTROL_1, d);
    apb(0, OFF_CONTROL_1, 0);
    `CHK(q, d & 32'h77)
    apb(0, 8'h18, 0);
    `CHK({e, q}, {1'b1, 32'h0})
    // locked straps
    restart(2'h3, 5'h05, 3'h1, 3'h3);
    apb(1, OFF_CONTROL_0, d);
    apb(0, OFF_CONTROL_0, 0);
    `CHK(q, {26'h0, 5'h05, d[0]})
    `CHK(wdt_active, 1'b1)
    apb(1, OFF_CONTROL_1, d);
    apb(0, OFF_CONTROL_1, 0);
    `CHK(q, 32'h13)
    restart(2'h0, 5'h1f, 3'h7, 3'h7);
    apb(1, OFF_CONTROL_0, 32'h01);
    `CHK(wdt_active, 1'b0)
    // time-outs for several periods and time bases
    restart(2'h1, 5'h1f, 3'h7, 3'h7);
    for (int i = 0; i < 4; i++) begin
      apb(1, OFF_CONTROL_1, 32'(sel[i] * 16 + 7));
      apb(1, OFF_CONTROL_0, 32'(pst[i] * 2 + 1));
      spin(sel[i], ticks(pst[i]) + 8);
      `CHK(hit, ticks(pst[i]))
      apb(0, OFF_CAUSE, 0);
      `CHK(q, 32'h1)
      apb(1, OFF_CAUSE, 32'h3);
    end
    // secondary oscillator start-up after a time-out
    apb(1, OFF_CONTROL_1, 32'h27);
    apb(1, OFF_CONTROL_0, 32'h01);
    spin(2, 40);
    `CHK(hit, 32)
    spin(2, 1000);
    `CHK(wdt_active, 1'b0)
    spin(2, 30);
    `CHK(wdt_active, 1'b1)
    // windowed clears
    apb(1, OFF_CONTROL_1, 32'h03);
    apb(1, OFF_CAUSE, 32'h3);
    pulse();
    `CHK(hit, 1)
    apb(0, OFF_CAUSE, 0);
    `CHK(q[1], 1'b1)
    apb(0, OFF_CONTROL_0, 0);
    pulse();
    `CHK(hit, 1)
    apb(0, OFF_CONTROL_0, 0);
    spin(0, 20);
    apb(0, OFF_TIMER_STATUS, 0);
    `CHK(q, 32'ha4)
    pulse();
    `CHK(hit, 0)
    apb(0, OFF_COUNT_LOW, 0);
    `CHK(q, 32'h0)
    // live count, then cleared by a control write
    spin(0, 10);
    apb(0, OFF_COUNT_LOW, 0);
    `CHK(q, 32'd10)
    apb(1, OFF_CONTROL_1, 32'h07);
    apb(0, OFF_COUNT_LOW, 0);
    `CHK(q, 32'h0)
    // sleep: always-on wakes instead of resetting, sleep-off mode halts until awake
    restart(2'h3, 5'h00, 3'h0, 3'h7);
    sleep <= 1'b1;
    spin(0, 40);
    `CHK(wk, 32)
    `CHK(hit, -1)
    restart(2'h2, 5'h00, 3'h0, 3'h7);
    spin(0, 40);
    `CHK(wdt_active, 1'b0)
    `CHK(wk, -1)
    sleep <= 1'b0;
    spin(0, 40);
    `CHK(hit, 32)
    wrap_up();
  end
endmodule
